// File: hw/rsce_pkg.sv
// constants and types shared by the reference select and clock export block
`default_nettype none
package rsce_pkg;
   // reference source choices for the loop
   typedef enum logic [1:0] {
      REF_NONE  = 2'b00,
      REF_FRONT = 2'b01,
      REF_BPLN  = 2'b10,
      REF_LOCAL = 2'b11
   } rsce_ref_t;
   // what an export destination carries
   typedef enum logic [1:0] {
      ROUTE_NONE   = 2'b00,
      ROUTE_SYNC   = 2'b01,
      ROUTE_SAMPLE = 2'b10,
      ROUTE_REF    = 2'b11
   } rsce_route_t;
   // destination indices: pin zero, pin one, trigger lines 0 to 6
   localparam int          NUM_DEST       = 9;
   localparam int          DEST_W         = 4;
   localparam logic [3:0]  DEST_PIN_ZERO  = 4'h0;
   localparam logic [3:0]  DEST_PIN_ONE   = 4'h1;
   localparam logic [3:0]  DEST_TRIG_BASE = 4'h2;
   // reset values
   localparam logic [1:0]  PIN_ZERO_RESET = 2'h1;
   localparam logic [1:0]  ROUTE_RESET    = 2'h0;
   localparam logic [1:0]  REF_RESET      = 2'h0;
   // refused route answer
   localparam logic signed [31:0] ERR_ROUTE_TAKEN = -32'sd89137;
   // reference frequency limits in MHz
   localparam logic [4:0]  REF_MHZ_MIN    = 5'h01;
   localparam logic [4:0]  REF_MHZ_MAX    = 5'h14;
   localparam logic [4:0]  REF_MHZ_SPEC   = 5'h05;
   // rates
   localparam int          CORE_MHZ       = 200;
   localparam int          SAMPLE_MHZ     = 100;
   localparam int          SAMPLE_HALF    = CORE_MHZ / (2 * SAMPLE_MHZ);
   localparam int          DIV_W          = 8;
   localparam int          NUM_SYNC_IN    = 4;
endpackage : rsce_pkg
`default_nettype wire

// File: hw/rsce_div.sv
// glitch-free integer divider for the exported sample clock
`default_nettype none
module rsce_div
   import rsce_pkg::*;
#(
   parameter int W = DIV_W
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // divisor, below 2 means no division
   input  wire logic [W-1:0] div_i,
   // divided clock level
   output logic              clk_o
);
   logic [W:0]   cnt;
   logic [W:0]   next_cnt;
   logic [W-1:0] cur;
   logic [W-1:0] next_cur;
   logic         next_clk;
   logic [W-1:0] eff;

   ////////////////////////////////////////////////////////////////////
   // divisor only taken at a period boundary so no runt pulse escapes
   always_comb begin
      eff      = (cur < W'(2)) ? W'(1) : cur;
      next_cur = cur;
      if (cnt == {eff, 1'b0} - (W+1)'(1)) begin
         next_cnt = '0;
         next_cur = div_i;
      end else begin
         next_cnt = cnt + (W+1)'(1);
      end
      next_clk = (next_cnt < {1'b0, (next_cnt == '0) ?
                  ((next_cur < W'(2)) ? W'(1) : next_cur) : eff});
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt   <= '0;
         cur   <= W'(1);
         clk_o <= 1'b1;
      end else begin
         cnt   <= next_cnt;
         cur   <= next_cur;
         clk_o <= next_clk;
      end
   end
endmodule : rsce_div
`default_nettype wire

// File: hw/rsce_top.sv
// reference select, phase compare and clock export for the signal generator
`default_nettype none
module rsce_top
   import rsce_pkg::*;
(
   // clock and reset
   input  wire logic                 CORE_CLK_I,
   input  wire logic                 RST_I,
   // reference pins and timebase feedback
   input  wire logic                 FRONT_REF_I,
   input  wire logic                 BPLN_REF_I,
   input  wire logic                 LOCAL_REF_I,
   input  wire logic                 TIMEBASE_FB_I,
   // configuration
   input  wire logic [1:0]           REF_SRC_I,
   input  wire logic [4:0]           REF_MHZ_I,
   input  wire logic [DIV_W-1:0]     EXP_DIV_I,
   input  wire logic                 LOCAL_EXPORT_I,
   input  wire logic                 SYNC_I,
   // route requests
   input  wire logic                 ROUTE_WR_I,
   input  wire logic [DEST_W-1:0]    ROUTE_DEST_I,
   input  wire logic [1:0]           ROUTE_SRC_I,
   output logic                      ROUTE_ERR_O,
   output logic signed [31:0]        ERR_CODE_O,
   // loop control
   output logic                      PD_UP_O,
   output logic                      PD_DN_O,
   output logic                      CAL_DAC_SEL_O,
   output logic                      REF_MHZ_OK_O,
   output logic                      REF_MHZ_SPEC_O,
   // sample timebase
   output logic                      SAMPLE_CLK_O,
   output logic                      SAMPLE_EN_O,
   // export destinations
   output logic [NUM_DEST-1:0]       DEST_O,
   output logic [NUM_DEST-1:0]       DEST_OE_O,
   output logic                      SYS_LINE_SEVEN_O,
   output logic                      SYS_LINE_SEVEN_OE_O
);
   ////////////////////////////////////////////////////////////////////
   // three-stage pin sampling, a change counts once stages two and three agree
   logic [NUM_SYNC_IN-1:0] pin_raw;
   logic [NUM_SYNC_IN-1:0] s1, s2, s3, filt;
   logic [NUM_SYNC_IN-1:0] next_filt;
   assign pin_raw = {TIMEBASE_FB_I, LOCAL_REF_I, BPLN_REF_I, FRONT_REF_I};

   always_comb begin
      next_filt = filt;
      for (int i = 0; i < NUM_SYNC_IN; i++) begin
         if (s2[i] == s3[i]) begin
            next_filt[i] = s3[i];
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '0;
      end else begin
         s1   <= pin_raw;
         s2   <= s1;
         s3   <= s2;
         filt <= next_filt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reference selection, switched only while old and new are both low
   rsce_ref_t ref_sel, next_ref_sel;
   logic      ref_now, ref_new, ref_prev, fb_prev;
   logic      next_ref_prev, next_fb_prev;
   logic      pd_up, pd_dn, next_pd_up, next_pd_dn;

   function automatic logic ref_level(input rsce_ref_t s, input logic [3:0] f);
      case (s)
         REF_FRONT: ref_level = f[0];
         REF_BPLN:  ref_level = f[1];
         REF_LOCAL: ref_level = f[2];
         default:   ref_level = 1'b0;
      endcase
   endfunction : ref_level

   always_comb begin
      ref_now       = ref_level(ref_sel, filt);
      ref_new       = ref_level(rsce_ref_t'(REF_SRC_I), filt);
      next_ref_sel  = ref_sel;
      if (!ref_now && !ref_new) begin
         next_ref_sel = rsce_ref_t'(REF_SRC_I);
      end
      next_ref_prev = ref_now;
      next_fb_prev  = filt[3];
      next_pd_up    = pd_up;
      next_pd_dn    = pd_dn;
      if (ref_sel == REF_NONE || next_ref_sel != ref_sel) begin
         next_pd_up = 1'b0;
         next_pd_dn = 1'b0;
      end else begin
         // edge-triggered phase-frequency compare against the feedback
         if (ref_now && !ref_prev) begin
            next_pd_up = 1'b1;
         end
         if (filt[3] && !fb_prev) begin
            next_pd_dn = 1'b1;
         end
         if (next_pd_up && next_pd_dn) begin
            next_pd_up = 1'b0;
            next_pd_dn = 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ref_sel  <= rsce_ref_t'(REF_RESET);
         ref_prev <= 1'b0;
         fb_prev  <= 1'b0;
         pd_up    <= 1'b0;
         pd_dn    <= 1'b0;
      end else begin
         ref_sel  <= next_ref_sel;
         ref_prev <= next_ref_prev;
         fb_prev  <= next_fb_prev;
         pd_up    <= next_pd_up;
         pd_dn    <= next_pd_dn;
      end
   end

   assign PD_UP_O        = pd_up;
   assign PD_DN_O        = pd_dn;
   assign CAL_DAC_SEL_O  = (ref_sel == REF_NONE);
   // frequency range is the configuring party's duty, only flagged here
   assign REF_MHZ_OK_O   = (REF_MHZ_I >= REF_MHZ_MIN) && (REF_MHZ_I <= REF_MHZ_MAX);
   assign REF_MHZ_SPEC_O = REF_MHZ_OK_O && (REF_MHZ_I >= REF_MHZ_SPEC);

   ////////////////////////////////////////////////////////////////////
   // sample timebase: toggles every core cycle for 100 MHz, plus its enable
   logic samp, next_samp;
   always_comb begin
      next_samp = (SAMPLE_HALF == 1) ? ~samp : samp;
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         samp <= 1'b1;
      end else begin
         samp <= next_samp;
      end
   end
   assign SAMPLE_CLK_O = samp;
   assign SAMPLE_EN_O  = ~samp;

   // divided sample clock for export
   logic samp_exp;
   rsce_div #(.W(DIV_W)) u_div (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .div_i (EXP_DIV_I),
      .clk_o (samp_exp)
   );

   ////////////////////////////////////////////////////////////////////
   // route table: one entry per destination, new route applied at a low point
   logic [1:0] route     [NUM_DEST];
   logic [1:0] pend      [NUM_DEST];
   logic [1:0] next_route[NUM_DEST];
   logic [1:0] next_pend [NUM_DEST];
   logic [NUM_DEST-1:0] lvl_now, lvl_new, next_dest, dest_q;
   logic       err, next_err;
   logic       ref_exp;
   // the local oscillator may leave only on system line seven, never by a route
   assign ref_exp = (ref_sel != REF_NONE) && (ref_sel != REF_LOCAL) && ref_now;

   function automatic logic src_level(input logic [1:0] r, input logic sy,
                                      input logic sc, input logic rf);
      case (rsce_route_t'(r))
         ROUTE_SYNC:   src_level = sy;
         ROUTE_SAMPLE: src_level = sc;
         ROUTE_REF:    src_level = rf;
         default:      src_level = 1'b0;
      endcase
   endfunction : src_level

   always_comb begin
      next_err = 1'b0;
      for (int d = 0; d < NUM_DEST; d++) begin
         next_pend[d] = pend[d];
      end
      if (ROUTE_WR_I && ROUTE_DEST_I < DEST_W'(NUM_DEST)) begin
         // trigger indices 2..8 serve both backplane and system lines 0 to 6
         if (ROUTE_DEST_I == DEST_PIN_ZERO && pend[0] == ROUTE_SYNC &&
             ROUTE_SRC_I != ROUTE_NONE && ROUTE_SRC_I != ROUTE_SYNC) begin
            next_err = 1'b1;
         end else begin
            next_pend[ROUTE_DEST_I] = ROUTE_SRC_I;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_DEST; g++) begin : g_dest
         always_comb begin
            lvl_now[g]    = src_level(route[g], SYNC_I, samp_exp, ref_exp);
            lvl_new[g]    = src_level(pend[g], SYNC_I, samp_exp, ref_exp);
            next_route[g] = route[g];
            if (!lvl_now[g] && !lvl_new[g]) begin
               next_route[g] = pend[g];
            end
            next_dest[g]  = src_level(next_route[g], SYNC_I, samp_exp, ref_exp);
         end
         always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
            if (RST_I) begin
               route[g]  <= (g == 0) ? PIN_ZERO_RESET : ROUTE_RESET;
               pend[g]   <= (g == 0) ? PIN_ZERO_RESET : ROUTE_RESET;
               dest_q[g] <= 1'b0;
            end else begin
               route[g]  <= next_route[g];
               pend[g]   <= next_pend[g];
               dest_q[g] <= next_dest[g];
            end
         end
         // unused destinations stay low and undriven
         assign DEST_OE_O[g] = (route[g] != ROUTE_NONE);
      end
   endgenerate

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         err <= 1'b0;
      end else begin
         err <= next_err;
      end
   end
   assign DEST_O      = dest_q;
   assign ROUTE_ERR_O = err;
   assign ERR_CODE_O  = err ? ERR_ROUTE_TAKEN : 32'sd0;

   ////////////////////////////////////////////////////////////////////
   // local reference goes out only on system line seven
   logic line7, next_line7;
   always_comb begin
      next_line7 = LOCAL_EXPORT_I & filt[2];
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         line7 <= 1'b0;
      end else begin
         line7 <= next_line7;
      end
   end
   assign SYS_LINE_SEVEN_O    = line7;
   assign SYS_LINE_SEVEN_OE_O = LOCAL_EXPORT_I;
endmodule : rsce_top
`default_nettype wire

// File: verification/rsce_ref_model.sv
// far side clocks: front and backplane references, local oscillator, timebase
`default_nettype none
module rsce_ref_model #(
   parameter realtime FRONT_HALF = 50.0,
   parameter realtime BPLN_HALF  = 49.9,
   parameter realtime TB_HALF    = 5.1
) (
   // reference clock pins
   output logic front_ref_o,
   output logic bpln_ref_o,
   output logic local_ref_o,
   // tuned crystal timebase fed back, slightly off so the compare has work
   output logic timebase_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // all start low, local half period 0.7 longer than front so its edges drift off the front edges
   initial begin
      front_ref_o = 1'b0;
      bpln_ref_o  = 1'b0;
      local_ref_o = 1'b0;
      timebase_o  = 1'b0;
   end
   // references run free, they are shared clocks
   always #(FRONT_HALF) front_ref_o = ~front_ref_o;
   always #(BPLN_HALF) bpln_ref_o = ~bpln_ref_o;
   always #(FRONT_HALF + 0.7) local_ref_o = ~local_ref_o;
   always #(TB_HALF) timebase_o = ~timebase_o;
endmodule : rsce_ref_model
`default_nettype wire

// File: verification/rsce_top_chk.sv
// concurrent checks on the clock select and export ports
`default_nettype none
module rsce_top_chk
   import rsce_pkg::*;
(
   // clock, reset and requests
   input wire logic                CORE_CLK_I,
   input wire logic                RST_I,
   input wire logic [4:0]          REF_MHZ_I,
   input wire logic                LOCAL_EXPORT_I,
   input wire logic                ROUTE_WR_I,
   input wire logic [DEST_W-1:0]   ROUTE_DEST_I,
   input wire logic [1:0]          ROUTE_SRC_I,
   // outputs watched
   input wire logic                ROUTE_ERR_O,
   input wire logic signed [31:0]  ERR_CODE_O,
   input wire logic                PD_UP_O,
   input wire logic                PD_DN_O,
   input wire logic                CAL_DAC_SEL_O,
   input wire logic                REF_MHZ_OK_O,
   input wire logic                REF_MHZ_SPEC_O,
   input wire logic                SAMPLE_CLK_O,
   input wire logic                SAMPLE_EN_O,
   input wire logic [NUM_DEST-1:0] DEST_O,
   input wire logic [NUM_DEST-1:0] DEST_OE_O,
   input wire logic                SYS_LINE_SEVEN_OE_O
);
   // one domain only
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);
   property p_err_code;
      ERR_CODE_O == (ROUTE_ERR_O ? ERR_ROUTE_TAKEN : 32'sh0);
   endproperty
   a_err_code: assert property (p_err_code) else $error("error code wrong");
   property p_err_cause;
      ROUTE_ERR_O |-> $past(ROUTE_WR_I && ROUTE_DEST_I == 4'h0 && ROUTE_SRC_I >= 2'h2);
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("refusal uncaused");
   property p_idle_loop;
      CAL_DAC_SEL_O && $past(CAL_DAC_SEL_O) |-> !PD_UP_O && !PD_DN_O;
   endproperty
   a_idle_loop: assert property (p_idle_loop) else $error("compare busy");
   // first edge after release still sees the reset level in $past
   property p_sample;
      !$past(RST_I) |-> $changed(SAMPLE_CLK_O) && SAMPLE_EN_O == !SAMPLE_CLK_O;
   endproperty
   a_sample: assert property (p_sample) else $error("timebase stalled");
   property p_local_oe;
      SYS_LINE_SEVEN_OE_O == LOCAL_EXPORT_I;
   endproperty
   a_local_oe: assert property (p_local_oe) else $error("line seven enable");
   property p_mhz;
      REF_MHZ_OK_O == (REF_MHZ_I >= 5'h01 && REF_MHZ_I <= 5'h14);
   endproperty
   a_mhz: assert property (p_mhz) else $error("range flag wrong");
   property p_spec;
      REF_MHZ_SPEC_O == (REF_MHZ_I >= 5'h05 && REF_MHZ_I <= 5'h14);
   endproperty
   a_spec: assert property (p_spec) else $error("spec flag wrong");
   property p_idle_dest;
      (~DEST_OE_O & ~$past(DEST_OE_O) & DEST_O) == '0;
   endproperty
   a_idle_dest: assert property (p_idle_dest) else $error("idle dest moves");
endmodule : rsce_top_chk
bind rsce_top rsce_top_chk u_rsce_top_chk (
   .CORE_CLK_I, .RST_I, .REF_MHZ_I, .LOCAL_EXPORT_I, .ROUTE_WR_I, .ROUTE_DEST_I,
   .ROUTE_SRC_I, .ROUTE_ERR_O, .ERR_CODE_O, .PD_UP_O, .PD_DN_O, .CAL_DAC_SEL_O,
   .REF_MHZ_OK_O, .REF_MHZ_SPEC_O, .SAMPLE_CLK_O, .SAMPLE_EN_O, .DEST_O, .DEST_OE_O,
   .SYS_LINE_SEVEN_OE_O
);
`default_nettype wire

// File: verification/rsce_top_tb.sv
// self-checking bench for the clock select and export block
`default_nettype none
module rsce_top_tb
   import rsce_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // stimulus
   logic                     clk = 1'b0;
   logic                     rst = 1'b1;
   logic                     wr = 1'b0;
   logic                     lexp = 1'b0;
   logic [1:0]               rsrc = 2'h0;
   logic [1:0]               rsel = 2'h0;
   logic [3:0]               dest = 4'h0;
   logic [DIV_W-1:0]         div = 8'h00;
   logic                     sync = 1'b0;
   logic [4:0]               mhz = 5'h0A;
   // design outputs and far side clocks
   wire logic                err, pdu, pdd, cal, mok, msp, sclk, sen, l7, l7oe;
   wire logic signed [31:0]  code;
   wire logic [NUM_DEST-1:0] dout, doe;
   wire logic                fr, bp, lr, tbk;
   int                       n_errors = 0;
   int                       checked = 0;
   always #2.5 clk = ~clk;
   rsce_ref_model u_rsce_ref_model (.front_ref_o(fr), .bpln_ref_o(bp), .local_ref_o(lr),
      .timebase_o(tbk));
   rsce_top u_rsce_top (.CORE_CLK_I(clk), .RST_I(rst), .FRONT_REF_I(fr), .BPLN_REF_I(bp),
      .LOCAL_REF_I(lr), .TIMEBASE_FB_I(tbk), .REF_SRC_I(rsrc), .REF_MHZ_I(mhz),
      .EXP_DIV_I(div), .LOCAL_EXPORT_I(lexp), .SYNC_I(sync), .ROUTE_WR_I(wr),
      .ROUTE_DEST_I(dest), .ROUTE_SRC_I(rsel), .ROUTE_ERR_O(err), .ERR_CODE_O(code),
      .PD_UP_O(pdu), .PD_DN_O(pdd), .CAL_DAC_SEL_O(cal), .REF_MHZ_OK_O(mok),
      .REF_MHZ_SPEC_O(msp), .SAMPLE_CLK_O(sclk), .SAMPLE_EN_O(sen), .DEST_O(dout),
      .DEST_OE_O(doe), .SYS_LINE_SEVEN_O(l7), .SYS_LINE_SEVEN_OE_O(l7oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   // 0..8 levels, 9..17 enables, then dac select, line seven, compare
   function automatic logic probe(input int k);
      if (k < 9) return dout[k];
      if (k < 18) return doe[k-9];
      if (k == 18) return cal;
      if (k == 19) return l7;
      return pdu | pdd;
   endfunction : probe
   // bounded wait, a miss ends the run; first look is a negedge on, never a launch edge
   task automatic waitv(input int k, input logic v);
      int n;
      @(negedge clk);
      for (n = 0; n < 600 && probe(k) !== v; n++) @(negedge clk);
      chk(n < 600, 1'b1);
      if (n == 600) complete_run();
   endtask : waitv
   // one request, then count refusal pulses for three cycles
   task automatic route(input logic [3:0] d, input logic [1:0] s, input int nerr);
      int n;
      @(posedge clk) begin
         wr <= 1'b1;
         dest <= d;
         rsel <= s;
      end
      @(posedge clk) wr <= 1'b0;
      n = 0;
      repeat (3) begin
         @(negedge clk);
         if (err === 1'b1) begin
            n++;
            chk(code, ERR_ROUTE_TAKEN);
         end
      end
      chk(n, nerr);
   endtask : route
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_refuse;
      @(negedge clk);
      chk(doe, 9'h001);
      chk(cal, 1'b1);
      @(posedge clk) sync <= 1'b1;
      waitv(0, 1'b1);
      route(4'h0, 2'h2, 1);
      route(4'h0, 2'h3, 1);
      // unroute while sync is high: the route must hold until the level drops
      route(4'h0, 2'h0, 0);
      chk(doe[0], 1'b1);
      @(posedge clk) sync <= 1'b0;
      waitv(9, 1'b0);
      route(4'h0, 2'h2, 0);
      waitv(9, 1'b1);
      waitv(0, 1'b1);
   endtask : t_refuse
   // sample clock on trigger line six, high time follows the divisor
   task automatic t_div;
      int n;
      route(4'h8, 2'h2, 0);
      waitv(17, 1'b1);
      for (int d = 0; d < 4; d++) begin
         @(posedge clk) div <= d[7:0];
         repeat (3) begin
            waitv(8, 1'b0);
            waitv(8, 1'b1);
         end
         for (n = 0; n < 20 && dout[8] === 1'b1; n++) @(negedge clk);
         chk(n, (d < 2) ? 1 : d);
      end
      chk(doe[8:2], 7'h40);
   endtask : t_div
   // every source drives the loop, front and backplane also pin one, none silences both
   task automatic t_ref;
      int n;
      route(4'h1, 2'h3, 0);
      waitv(10, 1'b1);
      for (int s = 1; s < 4; s++) begin
         @(posedge clk) rsrc <= s[1:0];
         waitv(18, 1'b0);
         waitv(20, 1'b1);
         if (s < 3) begin
            waitv(1, 1'b1);
            waitv(1, 1'b0);
         end else begin
            // local oscillator must never reach pin one; give the switch time first
            repeat (40) @(negedge clk);
            n = 0;
            repeat (60) @(negedge clk) if (dout[1] === 1'b1) n++;
            chk(n, 0);
         end
      end
      @(posedge clk) rsrc <= 2'h0;
      waitv(18, 1'b1);
      n = 0;
      repeat (60) @(negedge clk) if (dout[1] === 1'b1) n++;
      chk(n, 0);
      @(posedge clk) lexp <= 1'b1;
      waitv(19, 1'b1);
      waitv(19, 1'b0);
      chk(l7oe, 1'b1);
   endtask : t_ref
   // range flags across every code, then back to a legal 10 MHz setting
   task automatic t_mhz;
      for (int m = 0; m < 32; m++) begin
         @(posedge clk) mhz <= m[4:0];
         @(negedge clk);
         chk(mok, (m >= 1 && m <= 20));
         chk(msp, (m >= 5 && m <= 20));
      end
      @(posedge clk) mhz <= 5'h0A;
   endtask : t_mhz
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_refuse();
      t_div();
      t_ref();
      t_mhz();
      complete_run();
   end
endmodule : rsce_top_tb
`default_nettype wire
